// File: logic/fsr_pkg.sv
// fault status recorder package: offsets, bit positions, widths
package fsr_pkg;
  localparam int unsigned FSR_AW = 8;
  localparam int unsigned FSR_DW = 32;
  localparam logic [FSR_AW-1:0] FSR_CFG_OFS = 8'h14;
  localparam logic [FSR_AW-1:0] FSR_CFSR_OFS = 8'h28;
  localparam logic [FSR_AW-1:0] FSR_HFSR_OFS = 8'h2c;
  localparam logic [FSR_AW-1:0] FSR_MMFAR_OFS = 8'h34;
  localparam logic [FSR_AW-1:0] FSR_BUS_FAULT_ADDRESS_REG_OFS = 8'h38;
  localparam logic [FSR_DW-1:0] FSR_ZERO = 32'h0000_0000;
  // cfsr bit positions
  localparam int unsigned B_MISALIGN = 24;
  localparam int unsigned B_NO_COPROCESSOR_FLAG = 19;
  localparam int unsigned B_BADPC = 18;
  localparam int unsigned B_BADSTATE = 17;
  localparam int unsigned B_UNDEC = 16;
  localparam int unsigned B_BAVALID = 15;
  localparam int unsigned B_STKBUS = 12;
  localparam int unsigned B_UNSTKBUS = 11;
  localparam int unsigned B_ASYNC = 10;
  localparam int unsigned B_SYNC = 9;
  localparam int unsigned B_FETCHBUS = 8;
  localparam int unsigned B_MAVALID = 7;
  localparam int unsigned B_STKVIOL = 4;
  localparam int unsigned B_UNSTKVIOL = 3;
  localparam int unsigned B_DVIOL = 1;
  localparam int unsigned B_FVIOL = 0;
  // hfsr bit positions
  localparam int unsigned B_DBG = 31;
  localparam int unsigned B_FORCED = 30;
  localparam int unsigned B_VECT = 1;
  // config register: misalign trap enable
  localparam int unsigned B_TRAP_EN = 3;
  localparam logic [FSR_DW-1:0] CFSR_MASK = 32'h010f_9f9b;
  localparam logic [FSR_DW-1:0] HFSR_MASK = 32'hc000_0002;
  typedef enum logic [1:0] {
    FSR_SRC_NONE = 2'b00,
    FSR_SRC_BUS = 2'b01,
    FSR_SRC_MEM = 2'b10
  } fsr_addr_src_e;
endpackage : fsr_pkg

// File: logic/fsr_w1c_bank.sv
// sticky flag bank: hardware set wins over software write-one clear
`timescale 1ns/1ps
module fsr_w1c_bank #(
  parameter int unsigned WIDTH = 32,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flags_o
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  initial begin
    if (WIDTH < 1) $error("fsr_w1c_bank: WIDTH must be at least 1");
  end

  always_comb begin
    // flags hold until cleared; a set in the clear cycle survives
    flags_nxt = ((flags_r & ~clr_i) | set_i) & MASK;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;
endmodule : fsr_w1c_bank

// File: logic/fsr_recorder.sv
// fault status recorder: cause flags, hard fault status and fault addresses
`timescale 1ns/1ps
module fsr_recorder #(
  parameter int unsigned AW = fsr_pkg::FSR_AW
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [fsr_pkg::FSR_DW-1:0] reg_wdata_i,
  input wire logic [3:0] reg_be_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [fsr_pkg::FSR_DW-1:0] reg_rdata_o,
  // fault events from the core, one-cycle pulses
  input wire logic ev_misalign_i,
  input wire logic ev_misalign_multi_i,
  input wire logic ev_coproc_i,
  input wire logic ev_bad_pc_load_i,
  input wire logic ev_bad_state_i,
  input wire logic ev_bad_state_undef_i,
  input wire logic ev_undecodable_i,
  input wire logic ev_stack_bus_err_i,
  input wire logic ev_unstack_bus_err_i,
  input wire logic ev_async_bus_err_i,
  input wire logic ev_sync_bus_err_i,
  input wire logic ev_fetch_bus_err_i,
  input wire logic ev_fetch_issue_i,
  input wire logic ev_stack_viol_i,
  input wire logic ev_unstack_viol_i,
  input wire logic ev_data_viol_i,
  input wire logic ev_xn_fetch_i,
  input wire logic ev_escalated_i,
  input wire logic ev_vector_bus_err_i,
  input wire logic [fsr_pkg::FSR_DW-1:0] fault_addr_i,
  input wire logic [fsr_pkg::FSR_DW-1:0] fault_pc_i,
  // outputs toward the exception logic
  output logic usage_fault_o,
  output logic sp_adjust_o,
  output logic [fsr_pkg::FSR_DW-1:0] stacked_pc_o,
  output logic misalign_trap_enable_o
);
  import fsr_pkg::*;

  initial begin
    if (AW < 6) $error("fsr_recorder: AW too small for register map");
  end

  function automatic logic [FSR_DW-1:0] bit_at(input int unsigned pos, input logic v);
    logic [FSR_DW-1:0] m;
    m = FSR_ZERO;
    m[pos] = v;
    return m;
  endfunction : bit_at

  function automatic logic [FSR_DW-1:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic flag_ok(input logic [FSR_DW-1:0] mask, input int unsigned pos);
    return (pos < FSR_DW) && mask[pos];
  endfunction : flag_ok

  function automatic logic ofs_ok(input logic [FSR_AW-1:0] ofs);
    // word aligned, and no bit above the address port's width
    return (ofs[1:0] == 2'h0) && ((AW >= FSR_AW) || ((ofs >> AW) == '0));
  endfunction : ofs_ok

  // a flag outside its bank's mask would be dropped without a trace, so refuse such a map
  initial begin
    if (!flag_ok(CFSR_MASK, B_MISALIGN)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_NO_COPROCESSOR_FLAG)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_BADPC)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_BADSTATE)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_UNDEC)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_BAVALID)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_STKBUS)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_UNSTKBUS)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_ASYNC)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_SYNC)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_FETCHBUS)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_MAVALID)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_STKVIOL)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_UNSTKVIOL)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_DVIOL)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(CFSR_MASK, B_FVIOL)) $error("fsr_recorder: cfsr flag outside mask");
    if (!flag_ok(HFSR_MASK, B_DBG)) $error("fsr_recorder: hfsr flag outside mask");
    if (!flag_ok(HFSR_MASK, B_FORCED)) $error("fsr_recorder: hfsr flag outside mask");
    if (!flag_ok(HFSR_MASK, B_VECT)) $error("fsr_recorder: hfsr flag outside mask");
    // the usage causes are read as one contiguous slice
    if (B_MISALIGN < B_UNDEC) $error("fsr_recorder: usage flags out of order");
    // the trap enable is written through byte lane 0 only
    if (B_TRAP_EN >= FSR_DW / $bits(reg_be_i)) $error("fsr_recorder: trap enable not in lane 0");
    if (!ofs_ok(FSR_CFG_OFS)) $error("fsr_recorder: config offset unreachable");
    if (!ofs_ok(FSR_CFSR_OFS)) $error("fsr_recorder: cfsr offset unreachable");
    if (!ofs_ok(FSR_HFSR_OFS)) $error("fsr_recorder: hfsr offset unreachable");
    if (!ofs_ok(FSR_MMFAR_OFS)) $error("fsr_recorder: mmfar offset unreachable");
    if (!ofs_ok(FSR_BUS_FAULT_ADDRESS_REG_OFS)) $error("fsr_recorder: bus_fault_address_reg offset unreachable");
    // two registers on one offset would make the read mux ambiguous
    if (FSR_CFG_OFS == FSR_CFSR_OFS || FSR_CFG_OFS == FSR_HFSR_OFS ||
        FSR_CFG_OFS == FSR_MMFAR_OFS || FSR_CFG_OFS == FSR_BUS_FAULT_ADDRESS_REG_OFS ||
        FSR_CFSR_OFS == FSR_HFSR_OFS || FSR_CFSR_OFS == FSR_MMFAR_OFS ||
        FSR_CFSR_OFS == FSR_BUS_FAULT_ADDRESS_REG_OFS || FSR_HFSR_OFS == FSR_MMFAR_OFS ||
        FSR_HFSR_OFS == FSR_BUS_FAULT_ADDRESS_REG_OFS || FSR_MMFAR_OFS == FSR_BUS_FAULT_ADDRESS_REG_OFS) begin
      $error("fsr_recorder: two registers share an offset");
    end
  end

  // decode
  // reads always return the whole word; byte enables only steer writes
  logic wr_cfg;
  logic wr_cfsr;
  logic wr_hfsr;
  logic wr_mmfar;
  logic wr_bus_fault_address_reg;
  logic [FSR_DW-1:0] wmask;
  assign wmask = lane_mask(reg_be_i);
  assign wr_cfg = reg_wr_i && (reg_addr_i == FSR_CFG_OFS);
  assign wr_cfsr = reg_wr_i && (reg_addr_i == FSR_CFSR_OFS);
  assign wr_hfsr = reg_wr_i && (reg_addr_i == FSR_HFSR_OFS);
  assign wr_mmfar = reg_wr_i && (reg_addr_i == FSR_MMFAR_OFS);
  assign wr_bus_fault_address_reg = reg_wr_i && (reg_addr_i == FSR_BUS_FAULT_ADDRESS_REG_OFS);

  // config state
  logic trap_en_r;
  logic trap_en_nxt;
  always_comb begin
    trap_en_nxt = trap_en_r;
    // only lane 0 carries the enable; the other lanes are ignored
    if (wr_cfg && reg_be_i[0]) begin
      trap_en_nxt = reg_wdata_i[B_TRAP_EN];
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      trap_en_r <= 1'b0;
    end else begin
      trap_en_r <= trap_en_nxt;
    end
  end
  assign misalign_trap_enable_o = trap_en_r;

  // cause flags
  logic fetch_bus_set;
  logic bus_addr_set;
  logic mem_addr_set;
  logic bad_state_set;
  logic [FSR_DW-1:0] cfsr_set;
  logic [FSR_DW-1:0] cfsr_clr;
  logic [FSR_DW-1:0] cfsr_q;
  logic [FSR_DW-1:0] hfsr_set;
  logic [FSR_DW-1:0] hfsr_clr;
  logic [FSR_DW-1:0] hfsr_q;

  assign fetch_bus_set = ev_fetch_bus_err_i && ev_fetch_issue_i;
  assign bus_addr_set = ev_sync_bus_err_i;
  assign mem_addr_set = ev_data_viol_i;
  assign bad_state_set = ev_bad_state_i && !ev_bad_state_undef_i;

  always_comb begin
    cfsr_set = FSR_ZERO;
    cfsr_set |= bit_at(B_MISALIGN, (ev_misalign_i && trap_en_r) ||
                       ev_misalign_multi_i);
    cfsr_set |= bit_at(B_NO_COPROCESSOR_FLAG, ev_coproc_i);
    cfsr_set |= bit_at(B_BADPC, ev_bad_pc_load_i);
    cfsr_set |= bit_at(B_BADSTATE, bad_state_set);
    cfsr_set |= bit_at(B_UNDEC, ev_undecodable_i);
    cfsr_set |= bit_at(B_BAVALID, bus_addr_set);
    cfsr_set |= bit_at(B_STKBUS, ev_stack_bus_err_i);
    cfsr_set |= bit_at(B_UNSTKBUS, ev_unstack_bus_err_i);
    cfsr_set |= bit_at(B_ASYNC, ev_async_bus_err_i);
    cfsr_set |= bit_at(B_SYNC, ev_sync_bus_err_i);
    cfsr_set |= bit_at(B_FETCHBUS, fetch_bus_set);
    cfsr_set |= bit_at(B_MAVALID, mem_addr_set);
    cfsr_set |= bit_at(B_STKVIOL, ev_stack_viol_i);
    cfsr_set |= bit_at(B_UNSTKVIOL, ev_unstack_viol_i);
    cfsr_set |= bit_at(B_DVIOL, ev_data_viol_i);
    cfsr_set |= bit_at(B_FVIOL, ev_xn_fetch_i);
    // byte lanes let software reach each sub-field alone
    cfsr_clr = wr_cfsr ? (reg_wdata_i & wmask) : FSR_ZERO;
    // a later memory fault invalidates the bus address
    cfsr_clr |= bit_at(B_BAVALID, mem_addr_set);
  end

  always_comb begin
    hfsr_set = FSR_ZERO;
    hfsr_set |= bit_at(B_FORCED, ev_escalated_i);
    hfsr_set |= bit_at(B_VECT, ev_vector_bus_err_i);
    // write one clears; debug bit is never set here, so a stray 1 is harmless
    hfsr_clr = wr_hfsr ? (reg_wdata_i & wmask) : FSR_ZERO;
  end

  // separate banks keep the two registers' write-one-clear paths apart
  fsr_w1c_bank #(
    .WIDTH(FSR_DW),
    .MASK(CFSR_MASK)
  ) u_cfsr (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .set_i(cfsr_set),
    .clr_i(cfsr_clr),
    .flags_o(cfsr_q)
  );

  fsr_w1c_bank #(
    .WIDTH(FSR_DW),
    .MASK(HFSR_MASK)
  ) u_hfsr (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .set_i(hfsr_set),
    .clr_i(hfsr_clr),
    .flags_o(hfsr_q)
  );

  // fault address registers; reset clears both to zero
  logic [FSR_DW-1:0] bus_fault_address_reg_r;
  logic [FSR_DW-1:0] bus_fault_address_reg_nxt;
  logic [FSR_DW-1:0] mmfar_r;
  logic [FSR_DW-1:0] mmfar_nxt;
  always_comb begin
    bus_fault_address_reg_nxt = bus_fault_address_reg_r;
    mmfar_nxt = mmfar_r;
    if (wr_bus_fault_address_reg) begin
      bus_fault_address_reg_nxt = (bus_fault_address_reg_r & ~wmask) | (reg_wdata_i & wmask);
    end
    if (wr_mmfar) begin
      mmfar_nxt = (mmfar_r & ~wmask) | (reg_wdata_i & wmask);
    end
    // stacking, unstacking, async and fetch faults record no address
    // a capture in the same cycle as a software write wins, so no fault address is lost
    if (ev_sync_bus_err_i) begin
      bus_fault_address_reg_nxt = fault_addr_i;
    end
    if (ev_data_viol_i) begin
      mmfar_nxt = fault_addr_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bus_fault_address_reg_r <= FSR_ZERO;
      mmfar_r <= FSR_ZERO;
    end else begin
      bus_fault_address_reg_r <= bus_fault_address_reg_nxt;
      mmfar_r <= mmfar_nxt;
    end
  end

  // return address to stack: faulting instruction or preempted one as given by core
  logic [FSR_DW-1:0] spc_r;
  logic [FSR_DW-1:0] spc_nxt;
  logic usage_r;
  logic usage_nxt;
  logic spadj_r;
  logic spadj_nxt;
  logic usage_cause;
  logic pc_cause;
  logic stack_cause;
  logic unstack_cause;
  // usage_fault_o and sp_adjust_o are one-cycle pulses for the exception logic
  assign usage_cause = |cfsr_set[B_MISALIGN:B_UNDEC];
  assign pc_cause = usage_cause || ev_sync_bus_err_i || ev_data_viol_i || ev_xn_fetch_i ||
                    ev_vector_bus_err_i;
  assign stack_cause = ev_stack_bus_err_i || ev_stack_viol_i;
  assign unstack_cause = ev_unstack_bus_err_i || ev_unstack_viol_i;
  always_comb begin
    spc_nxt = spc_r;
    if (pc_cause) begin
      spc_nxt = fault_pc_i;
    end
    usage_nxt = usage_cause;
    // sp moves on entry-stacking faults, never on unstacking ones
    // an unstacking fault keeps the old frame, so it overrides a stacking one in that cycle
    spadj_nxt = stack_cause && !unstack_cause;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      spc_r <= FSR_ZERO;
      usage_r <= 1'b0;
      spadj_r <= 1'b0;
    end else begin
      spc_r <= spc_nxt;
      usage_r <= usage_nxt;
      spadj_r <= spadj_nxt;
    end
  end
  assign stacked_pc_o = spc_r;
  assign usage_fault_o = usage_r;
  assign sp_adjust_o = spadj_r;

  // read port: data one cycle after the strobe
  logic [FSR_DW-1:0] rdata_r;
  logic [FSR_DW-1:0] rdata_nxt;
  always_comb begin
    rdata_nxt = FSR_ZERO;
    if (reg_rd_i) begin
      case (reg_addr_i)
        FSR_CFG_OFS: rdata_nxt = bit_at(B_TRAP_EN, trap_en_r);
        FSR_CFSR_OFS: rdata_nxt = cfsr_q;
        FSR_HFSR_OFS: rdata_nxt = hfsr_q;
        FSR_MMFAR_OFS: rdata_nxt = mmfar_r;
        FSR_BUS_FAULT_ADDRESS_REG_OFS: rdata_nxt = bus_fault_address_reg_r;
        default: rdata_nxt = FSR_ZERO;
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_r <= FSR_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata_o = rdata_r;
endmodule : fsr_recorder

// File: test/fsr_recorder_sva.sv
// port checker for the fault status recorder
`timescale 1ns/1ps
module fsr_recorder_sva #(
  parameter int unsigned AW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [3:0] reg_be_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic ev_coproc_i,
  input wire logic ev_unstack_bus_err_i,
  input wire logic ev_sync_bus_err_i,
  input wire logic ev_data_viol_i,
  input wire logic [31:0] fault_pc_i,
  input wire logic usage_fault_o,
  input wire logic sp_adjust_o,
  input wire logic [31:0] stacked_pc_o,
  input wire logic misalign_trap_enable_o
);
  import fsr_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // rdata must drop back to zero so a stale word is never mistaken for a read
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == FSR_ZERO)
    else $error("read data not zero");
  cfsr_resv_a: assert property (reg_rd_i && reg_addr_i == FSR_CFSR_OFS
    |=> (reg_rdata_o & ~CFSR_MASK) == FSR_ZERO) else $error("cfsr reserved set");
  hfsr_resv_a: assert property (reg_rd_i && reg_addr_i == FSR_HFSR_OFS
    |=> (reg_rdata_o & ~HFSR_MASK) == FSR_ZERO) else $error("hfsr reserved set");
  usage_pulse_a: assert property (ev_coproc_i |-> ##[1:2] usage_fault_o)
    else $error("no usage fault");
  unstk_sp_a: assert property (ev_unstack_bus_err_i |=> !sp_adjust_o)
    else $error("sp adjusted on unstack");
  sync_pc_a: assert property (ev_sync_bus_err_i |=> stacked_pc_o == $past(fault_pc_i))
    else $error("sync pc wrong");
  dv_pc_a: assert property (ev_data_viol_i && !ev_sync_bus_err_i
    |=> stacked_pc_o == $past(fault_pc_i)) else $error("violation pc wrong");
  trap_en_a: assert property (reg_wr_i && reg_be_i[0] && reg_addr_i == FSR_CFG_OFS
    |=> misalign_trap_enable_o == $past(reg_wdata_i[B_TRAP_EN])) else $error("trap enable");
endmodule : fsr_recorder_sva

bind fsr_recorder fsr_recorder_sva #(.AW(AW)) u_sva (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_be_i(reg_be_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .ev_coproc_i(ev_coproc_i), .ev_unstack_bus_err_i(ev_unstack_bus_err_i),
  .ev_sync_bus_err_i(ev_sync_bus_err_i), .ev_data_viol_i(ev_data_viol_i),
  .fault_pc_i(fault_pc_i), .usage_fault_o(usage_fault_o), .sp_adjust_o(sp_adjust_o),
  .stacked_pc_o(stacked_pc_o), .misalign_trap_enable_o(misalign_trap_enable_o)
);

// File: test/fault_status_recorder_tb_top.sv
// self-checking bench for the fault status recorder
`timescale 1ns/1ps
module fault_status_recorder_tb_top;
  import fsr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [18:0] ev = '0;
  logic [31:0] fa = 32'h0;
  logic [31:0] fp = 32'h0;
  logic [31:0] rdat;
  logic [31:0] spc;
  logic uf;
  logic spa;
  logic ten;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2.5 mclk_i = ~mclk_i;
  fsr_recorder i_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_be_i(be), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .ev_misalign_i(ev[0]), .ev_misalign_multi_i(ev[1]), .ev_coproc_i(ev[2]),
    .ev_bad_pc_load_i(ev[3]), .ev_bad_state_i(ev[4]), .ev_bad_state_undef_i(ev[5]),
    .ev_undecodable_i(ev[6]), .ev_stack_bus_err_i(ev[7]), .ev_unstack_bus_err_i(ev[8]),
    .ev_async_bus_err_i(ev[9]), .ev_sync_bus_err_i(ev[10]), .ev_fetch_bus_err_i(ev[11]),
    .ev_fetch_issue_i(ev[12]), .ev_stack_viol_i(ev[13]), .ev_unstack_viol_i(ev[14]),
    .ev_data_viol_i(ev[15]), .ev_xn_fetch_i(ev[16]), .ev_escalated_i(ev[17]),
    .ev_vector_bus_err_i(ev[18]), .fault_addr_i(fa), .fault_pc_i(fp), .usage_fault_o(uf),
    .sp_adjust_o(spa), .stacked_pc_o(spc), .misalign_trap_enable_o(ten)
  );
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge mclk_i);
    ad <= a;
    wd <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wrt
  // rdata stands only in the cycle after the strobe, so sample just past that edge
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    ad <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    chk(n, e, rdat);
  endtask : rdc
  task automatic fire(input logic [18:0] m, input logic [31:0] a, input logic [31:0] p);
    @(posedge mclk_i);
    ev <= m;
    fa <= a;
    fp <= p;
    @(posedge mclk_i);
    ev <= '0;
  endtask : fire
  // debug bit 31 is always written as zero when clearing
  task automatic t_one(input int k, input int j, input logic [31:0] ec, input logic [31:0] eh);
    fire((19'h1 << k) | (19'h1 << j), 32'h0, 32'h0);
    rdc("cfsr", FSR_CFSR_OFS, ec);
    rdc("hfsr", FSR_HFSR_OFS, eh);
    wrt(FSR_CFSR_OFS, 32'hffff_ffff, 4'hf);
    wrt(FSR_HFSR_OFS, 32'h7fff_ffff, 4'hf);
    rdc("cfsr clr", FSR_CFSR_OFS, FSR_ZERO);
  endtask : t_one
  task automatic t_causes;
    t_one(0, 0, 32'h0, 32'h0);
    t_one(1, 1, 32'h0100_0000, 32'h0);
    t_one(2, 2, 32'h0008_0000, 32'h0);
    t_one(3, 3, 32'h0004_0000, 32'h0);
    t_one(4, 4, 32'h0002_0000, 32'h0);
    t_one(4, 5, 32'h0, 32'h0);
    t_one(6, 6, 32'h0001_0000, 32'h0);
    t_one(7, 7, 32'h0000_1000, 32'h0);
    t_one(8, 8, 32'h0000_0800, 32'h0);
    t_one(9, 9, 32'h0000_0400, 32'h0);
    t_one(11, 11, 32'h0, 32'h0);
    t_one(11, 12, 32'h0000_0100, 32'h0);
    t_one(13, 13, 32'h0000_0010, 32'h0);
    t_one(14, 14, 32'h0000_0008, 32'h0);
    t_one(16, 16, 32'h0000_0001, 32'h0);
    t_one(17, 17, 32'h0, 32'h4000_0000);
    t_one(18, 18, 32'h0, 32'h0000_0002);
    wrt(FSR_CFG_OFS, 32'h0000_0008, 4'h1);
    #1;
    chk("trap en", 32'h1, {31'h0, ten});
    t_one(0, 0, 32'h0100_0000, 32'h0);
  endtask : t_causes
  // sp adjust and usage fault stand one cycle, so look just past the event edge
  task automatic t_pulses;
    fire(19'h00080, 32'h0, 32'h0);
    #1;
    chk("sp adj stk", 32'h1, {31'h0, spa});
    fire(19'h02000, 32'h0, 32'h0);
    #1;
    chk("sp adj viol", 32'h1, {31'h0, spa});
    fire(19'h02100, 32'h0, 32'h0);
    #1;
    chk("sp adj unstk", 32'h0, {31'h0, spa});
    fire(19'h00004, 32'h0, 32'h0);
    #1;
    chk("usage", 32'h1, {31'h0, uf});
    fire(19'h00200, 32'h0, 32'h0);
    #1;
    chk("usage bus", 32'h0, {31'h0, uf});
    wrt(FSR_CFSR_OFS, 32'hffff_ffff, 4'hf);
  endtask : t_pulses
  task automatic t_addr;
    fire(19'h00400, 32'h2000_0010, 32'h0800_0100);
    rdc("bus_fault_address_reg", FSR_BUS_FAULT_ADDRESS_REG_OFS, 32'h2000_0010);
    chk("pc sync", 32'h0800_0100, spc);
    rdc("cfsr sync", FSR_CFSR_OFS, 32'h0000_8200);
    wrt(FSR_CFSR_OFS, 32'h0000_8000, 4'h2);
    rdc("cfsr bav clr", FSR_CFSR_OFS, 32'h0000_0200);
    fire(19'h08000, 32'h2000_0044, 32'h0800_0200);
    rdc("cfsr dv", FSR_CFSR_OFS, 32'h0000_0282);
    rdc("mmfar", FSR_MMFAR_OFS, 32'h2000_0044);
    chk("pc dv", 32'h0800_0200, spc);
    fire(19'h00200, 32'h3000_0000, 32'h0);
    rdc("bus_fault_address_reg async", FSR_BUS_FAULT_ADDRESS_REG_OFS, 32'h2000_0010);
    wrt(FSR_CFSR_OFS, 32'h0000_0080, 4'h1);
    rdc("cfsr byte", FSR_CFSR_OFS, 32'h0000_0602);
    wrt(FSR_CFSR_OFS, 32'hffff_ffff, 4'hf);
  endtask : t_addr
  task automatic t_sticky;
    fire(19'h00004, 32'h0, 32'h0);
    repeat (20) @(posedge mclk_i);
    rdc("sticky", FSR_CFSR_OFS, 32'h0008_0000);
    @(posedge mclk_i);
    ev <= 19'h00004;
    ad <= FSR_CFSR_OFS;
    wd <= 32'hffff_ffff;
    be <= 4'hf;
    wr <= 1'b1;
    @(posedge mclk_i);
    ev <= '0;
    wr <= 1'b0;
    rdc("set wins", FSR_CFSR_OFS, 32'h0008_0000);
    fire(19'h60000, 32'h0, 32'h0);
    wrt(FSR_HFSR_OFS, 32'h0000_0002, 4'hf);
    rdc("hfsr w1c", FSR_HFSR_OFS, 32'h4000_0000);
    wrt(8'h40, 32'hffff_ffff, 4'hf);
    rdc("unmapped", 8'h40, FSR_ZERO);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rdc("hfsr rst", FSR_HFSR_OFS, FSR_ZERO);
    rdc("cfsr rst", FSR_CFSR_OFS, FSR_ZERO);
  endtask : t_sticky
  // the run needs well under two thousand cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_causes();
    t_pulses();
    t_addr();
    t_sticky();
    give_verdict();
  end
endmodule : fault_status_recorder_tb_top
